// ### hw/mcs_pin_sync.sv
// Three-stage pin synchroniser with agreement filter and rise pulse.
`timescale 1ns/1ps
`default_nettype none
module mcs_pin_sync
  import mcs_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  input  wire logic pin,
  output var  logic level,
  output var  logic rise
);

  logic s1;
  logic s2;
  logic s3;

  // The first stage feeds only the second one.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // A change counts once the second and third stages agree.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      level <= 1'b0;
      rise  <= 1'b0;
    end else begin
      if (s2 == s3) begin
        level <= s3;
      end
      rise <= (s2 == s3) & s3 & ~level;
    end
  end

endmodule
`default_nettype wire

// ### hw/mcs_pkg.sv
// Constants, register map and state types of the motor mode block.
package mcs_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_MODE       = 8'h00;
  localparam logic [7:0] ADDR_CTRL       = 8'h04;
  localparam logic [7:0] ADDR_STATUS     = 8'h08;
  localparam logic [7:0] ADDR_PERIOD     = 8'h0C;
  localparam logic [7:0] ADDR_TIME_INDEX = 8'h10;
  localparam logic [7:0] ADDR_TGT_VEL    = 8'h14;
  localparam logic [7:0] ADDR_VEL_OFS    = 8'h18;
  localparam logic [7:0] ADDR_TGT_TRQ    = 8'h1C;
  localparam logic [7:0] ADDR_TRQ_OFS    = 8'h20;
  localparam logic [7:0] ADDR_MAX_TRQ    = 8'h24;
  localparam logic [7:0] ADDR_MAX_CUR    = 8'h28;
  localparam logic [7:0] ADDR_STEP_NUM   = 8'h2C;
  localparam logic [7:0] ADDR_STEP_DEN   = 8'h30;
  localparam logic [7:0] ADDR_SUBTYPE    = 8'h34;
  localparam logic [7:0] ADDR_FE_WINDOW  = 8'h38;
  localparam logic [7:0] ADDR_FE_TIMEOUT = 8'h3C;
  localparam logic [7:0] ADDR_CONFIG     = 8'h40;
  localparam logic [7:0] ADDR_DEMAND_POS = 8'h44;

  // ----------------------------------------------------------------
  // Mode codes, field positions and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  MODE_CSV       = 8'h09;
  localparam logic [7:0]  MODE_CST       = 8'h0A;
  localparam logic [7:0]  MODE_STEP      = 8'hFF;
  localparam logic [7:0]  MODE_SETUP     = 8'hFE;
  localparam logic [7:0]  TIME_INDEX_MS  = 8'hFD;
  localparam logic [7:0]  SUBTYPE_SD     = 8'h00;
  localparam logic [7:0]  SUBTYPE_DUAL   = 8'h01;
  localparam int          CW_START_BIT   = 4;
  localparam int          SW_SYNC_BIT    = 8;
  localparam int          SW_INDEX_BIT   = 10;
  localparam int          SW_FOLLOW_BIT  = 12;
  localparam int          SW_FE_BIT      = 13;
  localparam int          CFG_CL_BIT     = 0;
  localparam logic [7:0]  MODE_RST       = 8'h00;
  localparam logic [7:0]  PERIOD_RST     = 8'h01;
  localparam logic [15:0] STEP_NUM_RST   = 16'h0080;
  localparam logic [15:0] STEP_DEN_RST   = 16'h0001;
  localparam logic [15:0] TRQ_LIM_MAX    = 16'h7FFF;
  localparam logic [5:0]  DIV_BITS       = 6'h28;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ       = 20000;
  localparam int TIMEBASE_MS   = 1;
  localparam int CYCLES_PER_MS = TIMEBASE_MS * CLK_KHZ;

  // ----------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MCS_DIV_IDLE  = 3'b001,
    MCS_DIV_RUN   = 3'b010,
    MCS_DIV_APPLY = 3'b100
  } mcs_div_t;

  typedef enum logic [1:0] {
    MCS_SET_IDLE = 2'b01,
    MCS_SET_RUN  = 2'b10
  } mcs_setup_t;

endpackage

// ### hw/mcs_top.sv
// Mode logic for cyclic velocity, cyclic torque, stepping and auto setup.
//
// What this block does
// - Mode register selects 9, 10, -1, -2.
// - Cyclic modes ignore every control word bit.
// - Status bit 8 shows fieldbus synchronisation.
// - Status bit 12 shows setpoint being followed.
// - Cycle time is period times one millisecond.
// - Torque limited by smaller of two maxima.
// - Torque offset added to torque setpoint.
// - Velocity offset added to velocity setpoint.
// - Each step pulse moves one step.
// - Pulses summed per cycle, position updated.
// - Pulse scaled by numerator over denominator.
// - Status bit 13 flags following error.
// - Subtype 0: step pin plus direction pin.
// - Subtype 1: pulsing pin gives direction.
// - Setup starts on control bit 4 rising.
// - Status bit 10 shows index found.
// - Status bit 12 set after setup passes.
// - Closed loop allowed only after setup.
`timescale 1ns/1ps
`default_nettype none
module mcs_top
  import mcs_pkg::*;
#(
  parameter int CYC_PER_MS = CYCLES_PER_MS
) (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        fb_sync,
  input  wire logic        op_enabled,
  input  wire logic        step_pin,
  input  wire logic        dir_pin,
  input  wire logic [31:0] actual_pos,
  input  wire logic        setup_done,
  input  wire logic        setup_pass,
  input  wire logic        index_found,
  output var  logic [15:0] status_word,
  output var  logic [31:0] vel_demand,
  output var  logic [15:0] trq_demand,
  output var  logic [31:0] demand_pos,
  output var  logic        follow_on,
  output var  logic        closed_loop_on,
  output var  logic        setup_run
);

  // ----------------------------------------------------------------
  // Registers written by software
  // ----------------------------------------------------------------
  logic [7:0]  mode;
  logic [15:0] ctrl;
  logic [7:0]  period;
  logic [7:0]  time_index;
  logic [31:0] tgt_vel;
  logic [31:0] vel_ofs;
  logic [15:0] tgt_trq;
  logic [15:0] trq_ofs;
  logic [15:0] max_trq;
  logic [15:0] max_cur;
  logic [15:0] step_num;
  logic [15:0] step_den;
  logic [7:0]  subtype;
  logic [31:0] fe_window;
  logic [15:0] fe_timeout;
  logic        cfg_cl;

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  wire is_csv    = (mode == MODE_CSV);
  wire is_cst    = (mode == MODE_CST);
  wire is_step   = (mode == MODE_STEP);
  wire is_setup  = (mode == MODE_SETUP);
  wire is_cyclic = is_csv | is_cst;

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  wire apb_acc = psel & penable;
  wire apb_done = apb_acc & pready;
  wire wr_en = apb_done & pwrite;
  logic [31:0] rd_data;
  logic        addr_hit;

  // Ready comes one cycle into the access phase.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= apb_acc & ~pready;
      pslverr <= apb_acc & ~pready & ~addr_hit;
      prdata  <= (apb_acc & ~pready & ~pwrite) ? rd_data : 32'h0000_0000;
    end
  end

  // Read selection; unmapped addresses read as zero with an error.
  always_comb begin
    rd_data  = 32'h0000_0000;
    addr_hit = 1'b1;
    unique case (paddr)
      ADDR_MODE:       rd_data = {24'h00_0000, mode};
      ADDR_CTRL:       rd_data = {16'h0000, ctrl};
      ADDR_STATUS:     rd_data = {16'h0000, status_word};
      ADDR_PERIOD:     rd_data = {24'h00_0000, period};
      ADDR_TIME_INDEX: rd_data = {24'h00_0000, time_index};
      ADDR_TGT_VEL:    rd_data = tgt_vel;
      ADDR_VEL_OFS:    rd_data = vel_ofs;
      ADDR_TGT_TRQ:    rd_data = {16'h0000, tgt_trq};
      ADDR_TRQ_OFS:    rd_data = {16'h0000, trq_ofs};
      ADDR_MAX_TRQ:    rd_data = {16'h0000, max_trq};
      ADDR_MAX_CUR:    rd_data = {16'h0000, max_cur};
      ADDR_STEP_NUM:   rd_data = {16'h0000, step_num};
      ADDR_STEP_DEN:   rd_data = {16'h0000, step_den};
      ADDR_SUBTYPE:    rd_data = {24'h00_0000, subtype};
      ADDR_FE_WINDOW:  rd_data = fe_window;
      ADDR_FE_TIMEOUT: rd_data = {16'h0000, fe_timeout};
      ADDR_CONFIG:     rd_data = {31'h0000_0000, cfg_cl};
      ADDR_DEMAND_POS: rd_data = demand_pos;
      default:         addr_hit = 1'b0;
    endcase
  end

  // Register writes take effect on the completing access edge.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      mode       <= MODE_RST;
      ctrl       <= 16'h0000;
      period     <= PERIOD_RST;
      time_index <= TIME_INDEX_MS;
      tgt_vel    <= 32'h0000_0000;
      vel_ofs    <= 32'h0000_0000;
      tgt_trq    <= 16'h0000;
      trq_ofs    <= 16'h0000;
      max_trq    <= TRQ_LIM_MAX;
      max_cur    <= TRQ_LIM_MAX;
      step_num   <= STEP_NUM_RST;
      step_den   <= STEP_DEN_RST;
      subtype    <= SUBTYPE_SD;
      fe_window  <= 32'h0000_0000;
      fe_timeout <= 16'h0000;
      cfg_cl     <= 1'b0;
    end else if (wr_en) begin
      unique case (paddr)
        ADDR_MODE:       mode       <= pwdata[7:0];
        ADDR_CTRL:       ctrl       <= pwdata[15:0];
        ADDR_PERIOD:     period     <= pwdata[7:0];
        ADDR_TIME_INDEX: time_index <= pwdata[7:0];
        ADDR_TGT_VEL:    tgt_vel    <= pwdata;
        ADDR_VEL_OFS:    vel_ofs    <= pwdata;
        ADDR_TGT_TRQ:    tgt_trq    <= pwdata[15:0];
        ADDR_TRQ_OFS:    trq_ofs    <= pwdata[15:0];
        ADDR_MAX_TRQ:    max_trq    <= pwdata[15:0];
        ADDR_MAX_CUR:    max_cur    <= pwdata[15:0];
        ADDR_STEP_NUM:   step_num   <= pwdata[15:0];
        ADDR_STEP_DEN:   step_den   <= pwdata[15:0];
        ADDR_SUBTYPE:    subtype    <= pwdata[7:0];
        ADDR_FE_WINDOW:  fe_window  <= pwdata;
        ADDR_FE_TIMEOUT: fe_timeout <= pwdata[15:0];
        ADDR_CONFIG:     cfg_cl     <= pwdata[CFG_CL_BIT];
        default:         mode       <= mode;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Millisecond base and interpolation cycle
  // ----------------------------------------------------------------
  logic [15:0] ms_cnt;
  logic [7:0]  cyc_ms;
  wire timebase_ok = (time_index == TIME_INDEX_MS) & (period != 8'h00);
  wire ms_tick = (ms_cnt == 16'(CYC_PER_MS - 1));
  wire cycle_tick = ms_tick & timebase_ok & (cyc_ms == period - 8'h01);

  // Cycle length is the period value counted in milliseconds.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ms_cnt <= 16'h0000;
      cyc_ms <= 8'h00;
    end else begin
      ms_cnt <= ms_tick ? 16'h0000 : ms_cnt + 16'h0001;
      if (cycle_tick | ~timebase_ok) begin
        cyc_ms <= 8'h00;
      end else if (ms_tick) begin
        cyc_ms <= cyc_ms + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Fieldbus synchronisation and setpoint following
  // ----------------------------------------------------------------
  logic seen_sync;
  logic in_sync;
  wire next_seen = fb_sync | (seen_sync & ~cycle_tick);
  wire next_follow = is_cyclic & in_sync & op_enabled & timebase_ok;

  // A sync event in the closing cycle keeps the link in step.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      seen_sync <= 1'b0;
      in_sync   <= 1'b0;
      follow_on <= 1'b0;
    end else begin
      seen_sync <= next_seen;
      if (~timebase_ok | ~is_cyclic) begin
        in_sync <= 1'b0;
      end else if (cycle_tick) begin
        in_sync <= seen_sync | fb_sync;
      end
      follow_on <= next_follow;
    end
  end

  // ----------------------------------------------------------------
  // Velocity and torque demands
  // ----------------------------------------------------------------
  wire [31:0] vel_sum = tgt_vel + vel_ofs;
  wire signed [16:0] trq_sum = $signed({tgt_trq[15], tgt_trq})
                             + $signed({trq_ofs[15], trq_ofs});
  wire [15:0] trq_lim_raw = (max_trq < max_cur) ? max_trq : max_cur;
  wire [15:0] trq_lim = (trq_lim_raw > TRQ_LIM_MAX) ? TRQ_LIM_MAX : trq_lim_raw;
  wire signed [16:0] lim_pos = $signed({1'b0, trq_lim});
  wire signed [16:0] lim_neg = -lim_pos;
  wire [15:0] trq_clamp = (trq_sum > lim_pos) ? lim_pos[15:0]
                        : (trq_sum < lim_neg) ? lim_neg[15:0]
                        : trq_sum[15:0];

  // Demands take the setpoints once per cycle while following.
  // The master must have refreshed the setpoint by each cycle edge.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      vel_demand <= 32'h0000_0000;
      trq_demand <= 16'h0000;
    end else begin
      if (~is_csv | ~follow_on) begin
        vel_demand <= 32'h0000_0000;
      end else if (cycle_tick) begin
        vel_demand <= vel_sum;
      end
      if (~is_cst | ~follow_on) begin
        trq_demand <= 16'h0000;
      end else if (cycle_tick) begin
        trq_demand <= trq_clamp;
      end
    end
  end

  // ----------------------------------------------------------------
  // Step inputs and per-cycle pulse count
  // ----------------------------------------------------------------
  logic [1:0] pin_lvl;
  logic [1:0] pin_rise;
  wire  [1:0] pins = {dir_pin, step_pin};

  // Both pulse pins pass the same filtered synchroniser.
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_pin
      mcs_pin_sync u_sync (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .pin     (pins[gi]),
        .level   (pin_lvl[gi]),
        .rise    (pin_rise[gi])
      );
    end
  endgenerate

  // Direction level is taken as it stands at the step rise; no settling gap is checked.
  wire dual = (subtype == SUBTYPE_DUAL);
  wire up_sd = pin_rise[0] & pin_lvl[1];
  wire dn_sd = pin_rise[0] & ~pin_lvl[1];
  wire up_du = pin_rise[0] & ~pin_rise[1];
  wire dn_du = pin_rise[1] & ~pin_rise[0];
  wire step_up = is_step & (dual ? up_du : up_sd);
  wire step_dn = is_step & (dual ? dn_du : dn_sd);

  logic [23:0] pulse_cnt;
  wire [23:0] cnt_base = cycle_tick ? 24'h00_0000 : pulse_cnt;
  wire [23:0] next_cnt = step_up ? cnt_base + 24'h00_0001
                       : step_dn ? cnt_base - 24'h00_0001
                       : cnt_base;

  // A pulse in the cycle edge itself opens the new count.
  always_ff @(posedge clk_sys) begin
    if (sys_rst | ~is_step) begin
      pulse_cnt <= 24'h00_0000;
    end else begin
      pulse_cnt <= next_cnt;
    end
  end

  // ----------------------------------------------------------------
  // Scaling divider and demand position
  // ----------------------------------------------------------------
  mcs_div_t    div_st;
  logic [39:0] dvd;
  logic [16:0] rem;
  logic [5:0]  div_left;
  logic        div_neg;
  wire  [23:0] cnt_mag = pulse_cnt[23] ? -pulse_cnt : pulse_cnt;
  wire  [39:0] prod = 40'(cnt_mag) * 40'(step_num);
  wire  [15:0] den_eff = (step_den == 16'h0000) ? 16'h0001 : step_den;
  wire  [16:0] rem_sh = {rem[15:0], dvd[39]};
  wire         fits = (rem_sh >= {1'b0, den_eff});
  wire  [16:0] rem_sub = rem_sh - {1'b0, den_eff};
  wire  [31:0] quot = dvd[31:0];

  // Restoring division of the scaled count, one bit per clock.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      div_st     <= MCS_DIV_IDLE;
      dvd        <= 40'h00_0000_0000;
      rem        <= 17'h0_0000;
      div_left   <= 6'h00;
      div_neg    <= 1'b0;
      demand_pos <= 32'h0000_0000;
    end else begin
      unique case (div_st)
        MCS_DIV_IDLE: begin
          if (cycle_tick & is_step) begin
            dvd      <= prod;
            rem      <= 17'h0_0000;
            div_left <= DIV_BITS;
            div_neg  <= pulse_cnt[23];
            div_st   <= MCS_DIV_RUN;
          end
        end
        MCS_DIV_RUN: begin
          rem      <= fits ? rem_sub : rem_sh;
          dvd      <= {dvd[38:0], fits};
          div_left <= div_left - 6'h01;
          if (div_left == 6'h01) begin
            div_st <= MCS_DIV_APPLY;
          end
        end
        MCS_DIV_APPLY: begin
          demand_pos <= div_neg ? demand_pos - quot : demand_pos + quot;
          div_st     <= MCS_DIV_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Following error watch
  // ----------------------------------------------------------------
  logic [15:0] fe_cnt;
  logic        fe_flag;
  wire [31:0] pos_err = demand_pos - actual_pos;
  wire [31:0] err_mag = pos_err[31] ? -pos_err : pos_err;
  wire outside = is_step & closed_loop_on & (err_mag > fe_window);

  // Milliseconds outside the window are counted against the timeout.
  always_ff @(posedge clk_sys) begin
    if (sys_rst | ~outside) begin
      fe_cnt  <= 16'h0000;
      fe_flag <= 1'b0;
    end else begin
      if (ms_tick & (fe_cnt != 16'hFFFF)) begin
        fe_cnt <= fe_cnt + 16'h0001;
      end
      fe_flag <= (fe_cnt > fe_timeout);
    end
  end

  // ----------------------------------------------------------------
  // Auto setup sequence
  // ----------------------------------------------------------------
  mcs_setup_t set_st;
  logic       start_q;
  logic       aligned;
  logic       indexed;
  wire start_edge = is_setup & ctrl[CW_START_BIT] & ~start_q;

  // The setup travel runs until the motor side reports completion.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      set_st         <= MCS_SET_IDLE;
      start_q        <= 1'b0;
      aligned        <= 1'b0;
      indexed        <= 1'b0;
      setup_run      <= 1'b0;
      closed_loop_on <= 1'b0;
    end else begin
      start_q <= ctrl[CW_START_BIT];
      unique case (set_st)
        MCS_SET_IDLE: begin
          if (start_edge) begin
            set_st <= MCS_SET_RUN;
          end
        end
        MCS_SET_RUN: begin
          if (~is_setup) begin
            set_st <= MCS_SET_IDLE;
          end else if (setup_done) begin
            aligned <= setup_pass;
            indexed <= index_found;
            set_st  <= MCS_SET_IDLE;
          end
        end
      endcase
      setup_run      <= (set_st == MCS_SET_RUN) & is_setup & ~setup_done;
      closed_loop_on <= cfg_cl & aligned;
    end
  end

  // ----------------------------------------------------------------
  // Status word
  // ----------------------------------------------------------------
  wire [15:0] sw_cyc  = 16'(in_sync) << SW_SYNC_BIT
                      | 16'(follow_on) << SW_FOLLOW_BIT;
  wire [15:0] sw_step = 16'(fe_flag) << SW_FE_BIT;
  wire [15:0] sw_set  = 16'(indexed) << SW_INDEX_BIT
                      | 16'(aligned) << SW_FOLLOW_BIT;
  wire [15:0] next_sw = is_cyclic ? sw_cyc
                      : is_step ? sw_step
                      : is_setup ? sw_set
                      : 16'h0000;

  // Only the mode-specific bits are driven; all others read zero.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      status_word <= 16'h0000;
    end else begin
      status_word <= next_sw;
    end
  end

endmodule
`default_nettype wire

// ### test/mcs_monitor.sv
// Checker of bus and status timing of the motor mode block.
`timescale 1ns/1ps
`default_nettype none
module mcs_monitor (
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  input wire logic        op_enabled,
  input wire logic        setup_done,
  input wire logic [15:0] status_word,
  input wire logic [15:0] trq_demand,
  input wire logic        follow_on,
  input wire logic        closed_loop_on,
  input wire logic        setup_run
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // The first access cycle is answered exactly one cycle later.
  sequence acc_first;
    psel && penable && !$past(penable);
  endsequence
  sequence one_wait;
    !pready ##1 pready;
  endsequence
  ready_slot_a: assert property (acc_first |-> one_wait)
    else $error("bus answer not in second access cycle");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("bus answer longer than one cycle");
  err_data_a: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("refused access returned data");
  status_rsv_a: assert property ((status_word & 16'hCAFF) == 16'h0)
    else $error("reserved status bit set");
  fe_loop_a: assert property (status_word[13] |-> $past(closed_loop_on, 2))
    else $error("following error without closed loop");
  follow_en_a: assert property (follow_on |-> $past(op_enabled))
    else $error("setpoint followed without power stage");
  trq_lim_a: assert property (trq_demand != 16'h8000)
    else $error("torque demand outside limit");
  setup_end_a: assert property (setup_done |-> ##[1:2] !setup_run)
    else $error("setup travel runs on after completion");
endmodule
`default_nettype wire

// ### test/mcs_step_src.sv
// Step source model standing in for the positioning controller.
`timescale 1ns/1ps
`default_nettype none
module mcs_step_src (
  input  wire logic clk_sys,
  output var  logic step_pin,
  output var  logic dir_pin
);
  // ----------------------------------------
  // Pulse generation
  // ----------------------------------------
  // Both lines idle low from time zero.
  initial begin
    step_pin = 1'b0;
    dir_pin = 1'b0;
  end
  // Sends n pulses of 300 ns, 1.35 us apart, on one line.
  task automatic pulse(input logic on_dir, input int n);
    repeat (n) begin
      @(posedge clk_sys);
      if (on_dir) dir_pin <= 1'b1;
      else step_pin <= 1'b1;
      repeat (6) @(posedge clk_sys);
      if (on_dir) dir_pin <= 1'b0;
      else step_pin <= 1'b0;
      repeat (20) @(posedge clk_sys);
    end
  endtask
  // Sets the direction level, then lets it settle for 35 us.
  task automatic level(input logic v);
    @(posedge clk_sys);
    dir_pin <= v;
    repeat (700) @(posedge clk_sys);
  endtask
endmodule
`default_nettype wire

// ### test/tb.sv
// Self-checking bench of the motor mode block.
`timescale 1ns/1ps
`default_nettype none
module tb
  import mcs_pkg::*;
;
  // ----------------------------------------
  // Stimulus and checks
  // ----------------------------------------
  logic        clk_sys = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, fb_sync = 1'b0, op_enabled = 1'b0, sync_en = 1'b0;
  logic        setup_done = 1'b0, setup_pass = 1'b0, index_found = 1'b0, e;
  logic [7:0]  paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, actual_pos = 32'h0, q;
  wire  [31:0] prdata, vel_demand, demand_pos;
  wire  [15:0] status_word, trq_demand;
  wire         pready, pslverr, follow_on, closed_loop_on, setup_run, step_pin, dir_pin;
  int          errors = 0, checked = 0, tick = 0;
  logic [7:0]  ra [7] = '{ADDR_MODE, ADDR_PERIOD, ADDR_TIME_INDEX, ADDR_STEP_NUM,
                          ADDR_STEP_DEN, ADDR_MAX_TRQ, ADDR_MAX_CUR};
  logic [31:0] rv [7] = '{32'(MODE_RST), 32'(PERIOD_RST), 32'(TIME_INDEX_MS),
                          32'(STEP_NUM_RST), 32'(STEP_DEN_RST), 32'(TRQ_LIM_MAX),
                          32'(TRQ_LIM_MAX)};
  mcs_top #(.CYC_PER_MS(20)) uut (
    .clk_sys, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .fb_sync, .op_enabled, .step_pin, .dir_pin, .actual_pos,
    .setup_done, .setup_pass, .index_found, .status_word, .vel_demand,
    .trq_demand, .demand_pos, .follow_on, .closed_loop_on, .setup_run
  );
  mcs_step_src src (.clk_sys, .step_pin, .dir_pin);
  // Clock of 50 ns and a fieldbus sync pulse every 20 clocks.
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    tick <= (tick == 19) ? 0 : tick + 1;
    fb_sync <= sync_en && (tick == 0);
  end
  // Compares a value seen with the one expected.
  task automatic chk(input logic [31:0] s, input logic [31:0] x, input string n);
    checked++;
    if (s !== x) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, x, s);
    end
  endtask
  // One APB transfer; waits for pready, then releases the request.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // Rewrites a setpoint once in each of six cycles.
  task automatic feed(input logic [7:0] a, input logic [31:0] d);
    repeat (6) begin
      wr(a, d);
      cyc(16);
    end
  endtask
  task automatic print_verdict;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Watchdog against a hang.
  initial begin
    cyc(30000);
    errors++;
    print_verdict;
  end
  // Test sequence: reset values, cyclic modes, stepping, auto setup.
  initial begin
    cyc(10);
    sys_rst <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, ra[i], 32'h0);
      chk(q, rv[i], "reset value");
    end
    apb(1'b0, 8'h48, 32'h0);
    chk(32'(e), 32'h1, "unmapped");
    $display("test registers done");
    wr(ADDR_MODE, 32'(MODE_CSV));
    wr(ADDR_VEL_OFS, 32'h5);
    wr(ADDR_CTRL, 32'hFFFF_FFFF);
    op_enabled <= 1'b1;
    sync_en <= 1'b1;
    feed(ADDR_TGT_VEL, 32'h64);
    chk(vel_demand, 32'h69, "velocity");
    chk(32'(status_word), 32'h1100, "status");
    wr(ADDR_TIME_INDEX, 32'h0);
    cyc(60);
    chk(32'(follow_on), 32'h0, "follow");
    wr(ADDR_TIME_INDEX, 32'(TIME_INDEX_MS));
    sync_en <= 1'b0;
    cyc(60);
    chk(32'(status_word), 32'h0, "status");
    chk(vel_demand, 32'h0, "velocity");
    $display("test velocity done");
    sync_en <= 1'b1;
    wr(ADDR_MODE, 32'(MODE_CST));
    wr(ADDR_MAX_TRQ, 32'h12C);
    wr(ADDR_MAX_CUR, 32'hC8);
    feed(ADDR_TGT_TRQ, 32'h1F4);
    chk(32'(trq_demand), 32'hC8, "torque");
    wr(ADDR_MAX_CUR, 32'h1F4);
    wr(ADDR_TRQ_OFS, 32'hA);
    feed(ADDR_TGT_TRQ, 32'h1F4);
    chk(32'(trq_demand), 32'h12C, "torque");
    feed(ADDR_TGT_TRQ, 32'h32);
    chk(32'(trq_demand), 32'h3C, "torque");
    $display("test torque done");
    sync_en <= 1'b0;
    wr(ADDR_MODE, 32'(MODE_STEP));
    wr(ADDR_PERIOD, 32'h4);
    src.level(1'b1);
    src.pulse(1'b0, 3);
    cyc(200);
    chk(demand_pos, 32'h180, "position");
    src.level(1'b0);
    src.pulse(1'b0, 2);
    cyc(200);
    chk(demand_pos, 32'h80, "position");
    wr(ADDR_SUBTYPE, 32'(SUBTYPE_DUAL));
    wr(ADDR_STEP_NUM, 32'h200);
    wr(ADDR_STEP_DEN, 32'h2);
    src.pulse(1'b1, 1);
    cyc(200);
    chk(demand_pos, 32'hFFFF_FF80, "position");
    $display("test stepping done");
    wr(ADDR_MODE, 32'(MODE_SETUP));
    wr(ADDR_CONFIG, 32'h1);
    cyc(4);
    chk(32'(closed_loop_on), 32'h0, "loop");
    chk(32'(status_word), 32'h0, "status");
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_CTRL, 32'h10);
    cyc(3);
    chk(32'(setup_run), 32'h1, "setup run");
    setup_pass <= 1'b1;
    index_found <= 1'b1;
    setup_done <= 1'b1;
    cyc(1);
    setup_done <= 1'b0;
    cyc(4);
    chk(32'(status_word), 32'h1400, "status");
    chk(32'(closed_loop_on), 32'h1, "loop");
    wr(ADDR_MODE, 32'(MODE_STEP));
    wr(ADDR_FE_TIMEOUT, 32'h1);
    actual_pos <= 32'h1000_0000;
    cyc(100);
    chk(32'(status_word[13]), 32'h1, "following error");
    $display("test setup done");
    print_verdict;
  end
endmodule
bind mcs_top mcs_monitor mon (
  .clk_sys, .sys_rst, .psel, .penable, .pready, .pslverr, .prdata,
  .op_enabled, .setup_done, .status_word, .trq_demand, .follow_on,
  .closed_loop_on, .setup_run
);
`default_nettype wire
